// ---- include/srz_defines.svh ----
`ifndef SRZ_DEFINES_SVH
`define SRZ_DEFINES_SVH

// register map of the sequencer, word addresses on the software port
`define SRZ_ADDR_W 4
`define SRZ_REG_CTRL 4'h0
`define SRZ_REG_PULSE 4'h1
`define SRZ_REG_DELAY 4'h2
`define SRZ_REG_STATUS 4'h3
// control register fields
`define SRZ_CTRL_ZVS_BIT 0
`define SRZ_CTRL_VALLEY_BIT 1
// status register fields
`define SRZ_STAT_GATE_BIT 0
`define SRZ_STAT_MODE_BIT 1
`define SRZ_STAT_DCM_BIT 2
// counter width, reset values and count constants
`define SRZ_CNT_W 16
`define SRZ_PULSE_RST 16'h0010
`define SRZ_DELAY_RST 16'h0020
`define SRZ_CNT_ONE 16'h0001
`define SRZ_CNT_ZERO 16'h0000

`endif

// ---- include/srz_pkg.sv ----
package srz_pkg;
    typedef enum logic [2:0] {
        SRZ_IDLE = 3'b000,
        SRZ_COND = 3'b001,
        SRZ_WAIT = 3'b010,
        SRZ_PULSE = 3'b011,
        SRZ_DELAY = 3'b100,
        SRZ_REQ = 3'b101
    } srz_state_t;

    typedef logic [15:0] srz_count_t;
    typedef logic [3:0] srz_addr_t;
endpackage

// ---- include/srz_cfg_if.sv ----
`timescale 1ns/1ps
// configuration link between the host end and the sequencer
interface srz_cfg_if;
    logic zvsEnable;
    logic valleyEnable;
    logic [15:0] pulseCycles;
    logic [15:0] delayCycles;
    logic gateOn;
    logic zvsActive;
    logic dcmSeen;

    modport device (
        input zvsEnable,
        input valleyEnable,
        input pulseCycles,
        input delayCycles,
        output gateOn,
        output zvsActive,
        output dcmSeen
    );
    modport host (
        output zvsEnable,
        output valleyEnable,
        output pulseCycles,
        output delayCycles,
        input gateOn,
        input zvsActive,
        input dcmSeen
    );
endinterface

// ---- hw/srz_sequencer.sv ----
`timescale 1ns/1ps
`include "srz_defines.svh"
// Contract
// - valley mode: one rectifier pulse per cycle
// - continuous: gate off before next request
// - discontinuous valley: off below off threshold
// - zero-voltage continuous cycle equals valley mode
// - zero-voltage discontinuous: extra pulse before request
// - extra pulse length set by host
// - after pulse, gate off, programmed delay
// - reset leaves zero-voltage mode disabled
// - host toggles mode; disable reverts valley
// - never request while gate asserted
// - host enables valley switching with mode
// - valley mode request at winding peak
// - host sets delay near half ring
// - host serial clock 535 kHz or below; here the host writes a parallel register bus on the 100 MHz clock
// - host tunes settings before line sensing
module srz_sequencer (
    input wire logic clk,
    input wire logic arst_n,
    srz_cfg_if.device cfg,
    input wire logic condStart,
    input wire logic dropBelowThr,
    input wire logic needCycle,
    input wire logic fwdPeak,
    output logic gateOut,
    output logic primaryReq
);
    import srz_pkg::*;

    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic [3:0] syncA_q;
    logic [3:0] syncB_q;
    logic [3:0] syncA_d;
    logic [3:0] syncB_d;
    logic cStart;
    logic dropLow;
    logic needReq;
    logic peak;

    always_comb begin
        syncA_d = {fwdPeak, needCycle, dropBelowThr, condStart};
        syncB_d = syncA_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_q <= 4'h0;
            syncB_q <= 4'h0;
        end else begin
            syncA_q <= syncA_d;
            syncB_q <= syncB_d;
        end
    end

    assign cStart = syncB_q[0];
    assign dropLow = syncB_q[1];
    assign needReq = syncB_q[2];
    assign peak = syncB_q[3];

    // ==========================================================
    // sequencer
    // ==========================================================
    srz_state_t state_q;
    srz_state_t state_d;
    srz_count_t cnt_q;
    srz_count_t cnt_d;
    logic gate_q;
    logic gate_d;
    logic req_q;
    logic req_d;
    logic dcm_q;
    logic dcm_d;
    logic zvs_q;
    logic zvs_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        gate_d = gate_q;
        req_d = 1'b0;
        dcm_d = dcm_q;
        zvs_d = zvs_q;
        case (state_q)
            SRZ_IDLE: begin
                if (cStart) begin
                    state_d = SRZ_COND;
                    gate_d = 1'b1;
                    dcm_d = 1'b0;
                    zvs_d = cfg.zvsEnable;
                end
            end
            SRZ_COND: begin
                if (needReq) begin
                    // continuous cycle: drop gate, request next cycle
                    gate_d = 1'b0;
                    state_d = SRZ_REQ;
                end else if (dropLow) begin
                    gate_d = 1'b0;
                    dcm_d = 1'b1;
                    state_d = SRZ_WAIT;
                end
            end
            SRZ_WAIT: begin
                if (needReq && (zvs_q || !cfg.valleyEnable || peak)) begin
                    if (zvs_q) begin
                        gate_d = 1'b1;
                        cnt_d = (cfg.pulseCycles == `SRZ_CNT_ZERO) ?
                            `SRZ_CNT_ONE : cfg.pulseCycles;
                        state_d = SRZ_PULSE;
                    end else begin
                        state_d = SRZ_REQ;
                    end
                end
            end
            SRZ_PULSE: begin
                if (cnt_q == `SRZ_CNT_ONE) begin
                    gate_d = 1'b0;
                    cnt_d = cfg.delayCycles;
                    state_d = (cfg.delayCycles == `SRZ_CNT_ZERO) ? SRZ_REQ : SRZ_DELAY;
                end else begin
                    cnt_d = cnt_q - `SRZ_CNT_ONE;
                end
            end
            SRZ_DELAY: begin
                if (cnt_q <= `SRZ_CNT_ONE) begin
                    state_d = SRZ_REQ;
                end else begin
                    cnt_d = cnt_q - `SRZ_CNT_ONE;
                end
            end
            SRZ_REQ: begin
                req_d = ~gate_q;
                state_d = SRZ_IDLE;
            end
            default: begin
                state_d = SRZ_IDLE;
                gate_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= SRZ_IDLE;
            cnt_q <= `SRZ_CNT_ZERO;
            gate_q <= 1'b0;
            req_q <= 1'b0;
            dcm_q <= 1'b0;
            zvs_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            gate_q <= gate_d;
            req_q <= req_d;
            dcm_q <= dcm_d;
            zvs_q <= zvs_d;
        end
    end

    assign gateOut = gate_q;
    assign primaryReq = req_q;
    assign cfg.gateOn = gate_q;
    assign cfg.zvsActive = zvs_q;
    assign cfg.dcmSeen = dcm_q;
endmodule

// ---- hw/srz_host_cfg.sv ----
`timescale 1ns/1ps
`include "srz_defines.svh"
module srz_host_cfg (
    input wire logic clk,
    input wire logic arst_n,
    srz_cfg_if.host cfg,
    input wire srz_pkg::srz_addr_t addr,
    input wire logic [31:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdData
);
    import srz_pkg::*;

    // ==========================================================
    // configuration registers
    // ==========================================================
    logic zvs_q;
    logic zvs_d;
    logic valley_q;
    logic valley_d;
    srz_count_t pulse_q;
    srz_count_t pulse_d;
    srz_count_t delay_q;
    srz_count_t delay_d;
    logic [31:0] rd_q;
    logic [31:0] rd_d;

    always_comb begin
        zvs_d = zvs_q;
        valley_d = valley_q;
        pulse_d = pulse_q;
        delay_d = delay_q;
        rd_d = 32'h0;
        if (wrStb) begin
            case (addr)
                `SRZ_REG_CTRL: begin
                    zvs_d = wrData[`SRZ_CTRL_ZVS_BIT];
                    // valley switching follows the mode when enabling
                    valley_d = wrData[`SRZ_CTRL_VALLEY_BIT] |
                        wrData[`SRZ_CTRL_ZVS_BIT];
                end
                `SRZ_REG_PULSE: pulse_d = wrData[15:0];
                `SRZ_REG_DELAY: delay_d = wrData[15:0];
                default: begin
                end
            endcase
        end
        if (rdStb) begin
            case (addr)
                `SRZ_REG_CTRL: begin
                    rd_d[`SRZ_CTRL_ZVS_BIT] = zvs_q;
                    rd_d[`SRZ_CTRL_VALLEY_BIT] = valley_q;
                end
                `SRZ_REG_PULSE: rd_d[15:0] = pulse_q;
                `SRZ_REG_DELAY: rd_d[15:0] = delay_q;
                `SRZ_REG_STATUS: begin
                    rd_d[`SRZ_STAT_GATE_BIT] = cfg.gateOn;
                    rd_d[`SRZ_STAT_MODE_BIT] = cfg.zvsActive;
                    rd_d[`SRZ_STAT_DCM_BIT] = cfg.dcmSeen;
                end
                default: rd_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            zvs_q <= 1'b0;
            valley_q <= 1'b0;
            pulse_q <= `SRZ_PULSE_RST;
            delay_q <= `SRZ_DELAY_RST;
            rd_q <= 32'h0;
        end else begin
            zvs_q <= zvs_d;
            valley_q <= valley_d;
            pulse_q <= pulse_d;
            delay_q <= delay_d;
            rd_q <= rd_d;
        end
    end

    assign cfg.zvsEnable = zvs_q;
    assign cfg.valleyEnable = valley_q;
    assign cfg.pulseCycles = pulse_q;
    assign cfg.delayCycles = delay_q;
    assign rdData = rd_q;
endmodule

// ---- verification/srz_seq_properties.sv ----
`timescale 1ns/1ps
// ====================
// sequencer timing checks
module srz_seq_properties (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic zvsEnable,
    input wire logic [15:0] pulseCycles,
    input wire logic [15:0] delayCycles,
    input wire logic gateOut,
    input wire logic primaryReq,
    input wire logic needCycle,
    input wire logic dropBelowThr
);
    logic [1:0] riseCnt_q;
    logic [15:0] hiCnt_q;
    logic [15:0] loCnt_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // gate rises since the last request, and gate run lengths
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            riseCnt_q <= 2'h0;
            hiCnt_q <= 16'h0;
            loCnt_q <= 16'h0;
        end else begin
            riseCnt_q <= primaryReq ? 2'h0 : riseCnt_q + {1'b0, $rose(gateOut)};
            hiCnt_q <= gateOut ? hiCnt_q + 16'h1 : 16'h0;
            loCnt_q <= gateOut ? 16'h0 : loCnt_q + 16'h1;
        end
    end
    sequence s_first_on;
        gateOut && riseCnt_q == 2'h1 && !$rose(gateOut);
    endsequence
    sequence s_second_off;
        $fell(gateOut) && riseCnt_q == 2'h2;
    endsequence
    a_no_req_gate: assert property (primaryReq |-> !gateOut)
        else $error("request with gate on");
    a_req_single: assert property (primaryReq |=> !primaryReq)
        else $error("request longer than one cycle");
    a_req_after_off: assert property (primaryReq |-> !$past(gateOut))
        else $error("request not after gate off");
    a_qr_one_pulse: assert property (primaryReq && !zvsEnable |-> riseCnt_q == 2'h1)
        else $error("pulse count wrong in valley mode");
    a_zvs_pulse_len: assert property (s_second_off |->
        hiCnt_q == ((pulseCycles == 16'h0) ? 16'h1 : pulseCycles))
        else $error("extra pulse length wrong");
    a_zvs_delay: assert property (primaryReq && riseCnt_q == 2'h2 |->
        loCnt_q >= delayCycles && loCnt_q <= delayCycles + 16'h4)
        else $error("delay before request wrong");
    a_ccm_gate_off: assert property (s_first_on ##0 needCycle |-> ##[1:4] !gateOut)
        else $error("gate not off on new cycle");
    a_dcm_gate_off: assert property (s_first_on ##0 dropBelowThr |-> ##[1:4] !gateOut)
        else $error("gate not off below threshold");
endmodule

// ---- verification/sr_gate_zvs_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`include "srz_defines.svh"
module sr_gate_zvs_sequencer_tb_top;
    import srz_pkg::*;
    logic clk, arst_n, condStart, dropBelowThr, needCycle, fwdPeak, wrStb, rdStb;
    logic gateOut, primaryReq;
    srz_addr_t addr;
    logic [31:0] wrData, rdData;
    int badCount = 0;
    int cmpCount = 0;
    int cycCount = 0;
    srz_cfg_if cfgLink ();
    srz_sequencer srz_sequencer_inst (.clk(clk), .arst_n(arst_n), .cfg(cfgLink.device),
        .condStart(condStart), .dropBelowThr(dropBelowThr), .needCycle(needCycle),
        .fwdPeak(fwdPeak), .gateOut(gateOut), .primaryReq(primaryReq));
    srz_host_cfg srz_host_cfg_inst (.clk(clk), .arst_n(arst_n), .cfg(cfgLink.host),
        .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
    srz_seq_properties srz_seq_properties_inst (.clk(clk), .arst_n(arst_n),
        .zvsEnable(cfgLink.zvsEnable), .pulseCycles(cfgLink.pulseCycles),
        .delayCycles(cfgLink.delayCycles), .gateOut(gateOut), .primaryReq(primaryReq),
        .needCycle(needCycle), .dropBelowThr(dropBelowThr));
    // settings are written on the 100 MHz controller clock, far above the serial limit
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycCount++;
        if (cycCount == 20000) begin
            badCount++;
            printVerdict();
        end
    end
    // ====================
    // bus and check helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input srz_addr_t a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    task automatic rd(input srz_addr_t a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        @(negedge clk);
        check(what, rdData, exp);
    endtask
    // one switching cycle; counts the gate pulses up to the request
    task automatic run_cycle(input logic dcm, input logic [31:0] expRises, input string what);
        logic [31:0] rises;
        logic prev;
        logic reqSeen;
        rises = 0;
        prev = 1'b0;
        reqSeen = 1'b0;
        @(posedge clk);
        condStart <= 1'b1;
        for (int n = 0; n < 400; n++) begin
            @(negedge clk);
            if (primaryReq === 1'b1) begin
                reqSeen = 1'b1;
                break;
            end
            if (gateOut === 1'b1 && prev !== 1'b1) rises++;
            prev = gateOut;
            @(posedge clk);
            if (rises > 0) begin
                condStart <= 1'b0;
                dropBelowThr <= dcm;
                needCycle <= needCycle || !dcm || prev === 1'b0;
                fwdPeak <= needCycle || !dcm || prev === 1'b0;
            end
        end
        @(posedge clk);
        condStart <= 1'b0;
        dropBelowThr <= 1'b0;
        needCycle <= 1'b0;
        fwdPeak <= 1'b0;
        check(what, rises, expRises);
        check("request issued", {31'h0, reqSeen}, 32'h1);
        repeat (4) @(posedge clk);
    endtask
    // ====================
    // scenarios
    task automatic t_reset_values();
        rd(`SRZ_REG_CTRL, 32'h0, "ctrl");
        rd(`SRZ_REG_PULSE, 32'(`SRZ_PULSE_RST), "pulse");
        rd(`SRZ_REG_DELAY, 32'(`SRZ_DELAY_RST), "delay");
        wr(4'hf, 32'hffff_ffff);
        rd(4'hf, 32'h0, "unmapped");
        rd(`SRZ_REG_CTRL, 32'h0, "ctrl after unmapped write");
    endtask
    task automatic t_valley_cycles();
        run_cycle(1'b0, 32'h1, "qr ccm pulses");
        run_cycle(1'b1, 32'h1, "qr dcm pulses");
        wr(`SRZ_REG_CTRL, 32'h2);
        run_cycle(1'b1, 32'h1, "valley dcm pulses");
    endtask
    task automatic t_zvs_cycles();
        // pulse and delay are tuned before the mode is used
        wr(`SRZ_REG_PULSE, 32'h3);
        wr(`SRZ_REG_DELAY, 32'h5);
        wr(`SRZ_REG_CTRL, 32'h1);
        rd(`SRZ_REG_CTRL, 32'h3, "ctrl zv");
        run_cycle(1'b0, 32'h1, "zv ccm pulses");
        run_cycle(1'b1, 32'h2, "zv dcm pulses");
        wr(`SRZ_REG_PULSE, 32'h0);
        run_cycle(1'b1, 32'h2, "zv short pulses");
    endtask
    task automatic t_zvs_disable();
        wr(`SRZ_REG_CTRL, 32'h0);
        run_cycle(1'b1, 32'h1, "disabled dcm pulses");
        rd(`SRZ_REG_STATUS, 32'h4, "status");
    endtask
    task automatic printVerdict();
        $display("comparisons %0d, mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        {condStart, dropBelowThr, needCycle, fwdPeak, wrStb, rdStb} = 6'h0;
        addr = 4'h0;
        wrData = 32'h0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_values();
        t_valley_cycles();
        t_zvs_cycles();
        t_zvs_disable();
        printVerdict();
    end
endmodule
